// ==== hw/rsm_consts.vh ====
`ifndef RSM_CONSTS_VH
`define RSM_CONSTS_VH

// ****************************************************************
// Instruction word layout
// ****************************************************************
`define RSM_OP_HI      35
`define RSM_OP_LO      30
`define RSM_U_HI       29
`define RSM_U_LO       15
`define RSM_V_HI       14
`define RSM_V_LO       0
`define RSM_J_HI       14
`define RSM_J_LO       12
`define RSM_N_HI       11
`define RSM_N_LO       0
`define RSM_K_HI       6
`define RSM_K_LO       0

// ****************************************************************
// Operation codes (six-bit hex values)
// ****************************************************************
`define RSM_OP_REPLACE_ADD     6'h11
`define RSM_OP_REPLACE_SUB     6'h13
`define RSM_OP_CTRL_COMPL      6'h17
`define RSM_OP_ZEXT_LOAD       6'h19
`define RSM_OP_ZEXT_ADD        6'h1A
`define RSM_OP_ZEXT_NEG_LOAD   6'h1B
`define RSM_OP_ZEXT_SUB        6'h1C
`define RSM_OP_IDX_DEC_JUMP    6'h21
`define RSM_OP_THRESH_JUMP     6'h22
`define RSM_OP_EQUAL_JUMP      6'h23
`define RSM_OP_MASK_MOVE       6'h29
`define RSM_OP_MASK_ACC        6'h2A
`define RSM_OP_MASK_MERGE      6'h2B
`define RSM_OP_ROT_ACC_STORE   6'h2C
`define RSM_OP_ROT_Q_STORE     6'h2D
`define RSM_OP_MULTIPLY        6'h39
`define RSM_OP_MUL_ACC         6'h3A
`define RSM_OP_DIVIDE          6'h3B
`define RSM_OP_NORM_COUNT      6'h3C
`define RSM_OP_REPEAT_NEXT     6'h3D

// ****************************************************************
// Fixed addresses and sequence counts
// ****************************************************************
`define RSM_EXIT_CELL_LOW      15'h0000
`define RSM_EXIT_CELL_HIGH     15'h4001
`define RSM_ADDR_ACC_DEF       15'h7FFF
`define RSM_MUL_STEPS          7'h24
`define RSM_DIV_STEPS          7'h48
`define RSM_NORM_FIRST         7'h24
`define RSM_NORM_TURN          7'h48
`define RSM_NORM_LIMIT         7'h6C

`endif

// ==== hw/rsm_rotl.v ====
`timescale 1ns/10ps

// ****************************************************************
// Left circular rotate by a count taken modulo the width
// ****************************************************************
module rsm_rotl #(
	parameter W  = 72,
	parameter KW = 7
) (
	// Data
	input  wire [W-1:0]  din,
	input  wire [KW-1:0] k,
	output wire [W-1:0]  dout
);

	wire [KW-1:0]  k_mod;
	wire [31:0]    k_full;
	wire [2*W-1:0] dbl;

	assign k_full = k % W;
	assign k_mod  = k_full[KW-1:0];
	assign dbl   = {din, din} << k_mod;
	assign dout  = dbl[2*W-1:W];

endmodule

// ==== hw/rsm_exec.v ====
// Summary of operation
// - Instruction word: opcode bits 35..30, u bits 29..15, v bits 14..0.
// - j is u top three bits, n is u low twelve, k is low seven bits.
// - Sign extension copies bit 35 left; zero extension fills left half with zeros.
// - Masked operand is operand AND Q in right half; complement form uses inverted Q.
// - replace_add: A gets sign-extended u plus v; right half stored to u.
// - replace_subtract: A gets sign-extended u minus v; right half stored to u.
// - controlled_complement: right half gets u XOR v, left kept, stored to u.
// - rotate_acc_left_store: load u unless u is A, rotate by k, store to u.
// - rotate_q_left_store: Q gets u rotated left by k, also written to u.
// - Storing right half or Q back to memory leaves A and Q unchanged.
// - Split group: zero-extended u loaded, added, complemented or subtracted, rotated by k.
// - mask_move: A gets masked u; right half written to v.
// - mask_accumulate: masked u added to A; right half written to v.
// - mask_merge: v gets u bits where Q is one, old v bits elsewhere.
// - multiply: A gets 72-bit product of u and v, Q keeps u.
// - mul_accumulate: product added to A, Q keeps u, sign overflow raises fault.
// - divide: A by u, quotient to Q and v, non-negative remainder in A.
// - normalize_count: rotate 36 then until bits 34,35 differ; restoring count to v.
// - repeat_next: write w into exit cell, repeat next instruction n times, exit.
// - A taken jump inside a repetition ends the repetition at once.
// - Repeated threshold or equality jump taken loads Q with j and n minus runs.
// - index_decrement_jump: A gets u minus one; if non-negative store u and jump.
// - threshold_jump: jump when u exceeds A; A untouched.
// - equality_jump: jump when u equals A; A untouched.
`timescale 1ns/10ps
`include "rsm_consts.vh"

module rsm_exec #(
	parameter [14:0] ADDR_ACC  = `RSM_ADDR_ACC_DEF,
	parameter [14:0] EXIT_CELL = `RSM_EXIT_CELL_LOW
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_n,
	// Instruction from fetch control
	input  wire        instr_valid,
	input  wire [35:0] instr_word,
	output reg         busy,
	output reg         done,
	output reg         next_jump,
	output reg  [14:0] next_addr,
	// Addressed storage
	output reg         mem_rd_en,
	output reg         mem_wr_en,
	output reg  [14:0] mem_addr,
	output reg  [35:0] mem_wr_data,
	input  wire [35:0] mem_rd_data,
	// Arithmetic registers and fault lamp
	output reg  [71:0] acc,
	output reg  [35:0] q_reg,
	output reg         fault,
	input  wire        fault_clear
);

	// ****************************************************************
	// States
	// ****************************************************************
	localparam [9:0] ST_IDLE = 10'h001;
	localparam [9:0] ST_RDU  = 10'h002;
	localparam [9:0] ST_RDV  = 10'h004;
	localparam [9:0] ST_EXEC = 10'h008;
	localparam [9:0] ST_MUL  = 10'h010;
	localparam [9:0] ST_DIV  = 10'h020;
	localparam [9:0] ST_NORM = 10'h040;
	localparam [9:0] ST_RMW  = 10'h080;
	localparam [9:0] ST_WR   = 10'h100;
	localparam [9:0] ST_FIN  = 10'h200;

	reg  [9:0]  state;
	reg  [5:0]  op;
	reg  [14:0] u;
	reg  [14:0] v;
	reg  [35:0] opu;
	reg  [35:0] opv;
	reg  [6:0]  cnt;
	reg  [71:0] wa;
	reg  [71:0] wb;
	reg  [36:0] rem;
	reg         neg_a;
	reg         neg_d;
	reg         jmp;
	reg  [14:0] jmp_addr;
	reg  [14:0] rmw_val;
	// Repetition control
	reg         rep_armed;
	reg         rep_run;
	reg  [2:0]  rep_j;
	reg  [11:0] rep_n;
	reg  [11:0] rep_r;
	reg  [14:0] rep_w;

	// ****************************************************************
	// Operand forms
	// ****************************************************************
	wire        needs_v;
	wire [71:0] du;
	wire [71:0] dv;
	wire [71:0] su;
	wire [71:0] mask_u;
	wire [35:0] merge_v;
	wire [71:0] sum_uv;
	wire [71:0] dif_uv;
	wire [71:0] mask_sum;
	wire [71:0] idx_dec;
	wire [6:0]  k;
	reg  [71:0] pre_a;
	wire [71:0] rot_a;
	wire [35:0] rot_q;
	wire [71:0] pre_norm;

	assign needs_v = (op == `RSM_OP_REPLACE_ADD) || (op == `RSM_OP_REPLACE_SUB) ||
		(op == `RSM_OP_CTRL_COMPL) || (op == `RSM_OP_MASK_MERGE) ||
		(op == `RSM_OP_MULTIPLY) || (op == `RSM_OP_MUL_ACC);
	assign du       = {{36{opu[35]}}, opu};
	assign dv       = {{36{opv[35]}}, opv};
	assign su       = {36'h0, opu};
	assign mask_u   = {36'h0, opu & q_reg};
	assign merge_v  = (opu & q_reg) | (opv & ~q_reg);
	assign sum_uv   = du + dv;
	assign dif_uv   = du - dv;
	assign mask_sum = acc + mask_u;
	assign idx_dec  = du - 72'h1;
	assign k        = v[`RSM_K_HI:`RSM_K_LO];
	assign pre_norm = (u == ADDR_ACC) ? acc : du;

	always @* begin
		case (op)
			`RSM_OP_ROT_ACC_STORE: pre_a = (u == ADDR_ACC) ? acc : du;
			`RSM_OP_ZEXT_LOAD:     pre_a = su;
			`RSM_OP_ZEXT_ADD:      pre_a = acc + su;
			`RSM_OP_ZEXT_NEG_LOAD: pre_a = ~su;
			`RSM_OP_ZEXT_SUB:      pre_a = acc - su;
			default:               pre_a = acc;
		endcase
	end

	rsm_rotl #(.W(72), .KW(7)) u_rot_a (
		.din  (pre_a),
		.k    (k),
		.dout (rot_a)
	);

	rsm_rotl #(.W(36), .KW(7)) u_rot_q (
		.din  (opu),
		.k    (k),
		.dout (rot_q)
	);

	// ****************************************************************
	// Sequence results
	// ****************************************************************
	// The multiply works on magnitudes so the loop stays a plain shift-add;
	// the sign is applied once at the end.
	wire [71:0] prod;
	wire [71:0] prod_sum;
	wire        prod_ovf;
	wire [36:0] rem_sh;
	wire        rem_ge;
	wire [71:0] q_mag;
	wire [35:0] r_fin;
	wire [71:0] q_fin;
	wire [35:0] d_mag;
	wire [6:0]  norm_k;

	assign prod     = neg_a ? (72'h0 - wa) : wa;
	assign prod_sum = acc + prod;
	assign prod_ovf = (acc[71] == prod[71]) && (prod_sum[71] != acc[71]);
	assign d_mag    = wb[35:0];
	assign rem_sh   = {rem[35:0], wa[71]};
	assign rem_ge   = (rem_sh >= {1'b0, d_mag});
	assign q_mag    = (neg_a && (rem[35:0] != 36'h0)) ? (wa + 72'h1) : wa;
	assign r_fin    = (neg_a && (rem[35:0] != 36'h0)) ? (d_mag - rem[35:0]) : rem[35:0];
	assign q_fin    = (neg_a ^ neg_d) ? (72'h0 - q_mag) : q_mag;
	assign norm_k   = (cnt == `RSM_NORM_LIMIT) ? 7'h00 :
		(cnt > `RSM_NORM_TURN) ? (`RSM_NORM_TURN - (cnt - `RSM_NORM_TURN)) :
		(`RSM_NORM_TURN - cnt);

	// ****************************************************************
	// Control sequence
	// ****************************************************************
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state       <= ST_IDLE;
			busy        <= 1'b0;
			done        <= 1'b0;
			next_jump   <= 1'b0;
			next_addr   <= 15'h0000;
			mem_rd_en   <= 1'b0;
			mem_wr_en   <= 1'b0;
			mem_addr    <= 15'h0000;
			mem_wr_data <= 36'h0;
			acc         <= 72'h0;
			q_reg       <= 36'h0;
			fault       <= 1'b0;
			op          <= 6'h00;
			u           <= 15'h0000;
			v           <= 15'h0000;
			opu         <= 36'h0;
			opv         <= 36'h0;
			cnt         <= 7'h00;
			wa          <= 72'h0;
			wb          <= 72'h0;
			rem         <= 37'h0;
			neg_a       <= 1'b0;
			neg_d       <= 1'b0;
			jmp         <= 1'b0;
			jmp_addr    <= 15'h0000;
			rmw_val     <= 15'h0000;
			rep_armed   <= 1'b0;
			rep_run     <= 1'b0;
			rep_j       <= 3'h0;
			rep_n       <= 12'h000;
			rep_r       <= 12'h000;
			rep_w       <= 15'h0000;
		end else begin
			done <= 1'b0;
			if (fault_clear)
				fault <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (instr_valid) begin
						busy <= 1'b1;
						op   <= instr_word[`RSM_OP_HI:`RSM_OP_LO];
						u    <= instr_word[`RSM_U_HI:`RSM_U_LO];
						v    <= instr_word[`RSM_V_HI:`RSM_V_LO];
						jmp  <= 1'b0;
						if (rep_armed) begin
							rep_armed <= 1'b0;
							rep_run   <= 1'b1;
							rep_r     <= 12'h000;
						end
						if (rep_armed && (rep_n == 12'h000)) begin
							rep_run <= 1'b0;
							jmp      <= 1'b1;
							jmp_addr <= EXIT_CELL;
							state    <= ST_FIN;
						end else begin
							mem_rd_en <= 1'b1;
							mem_addr  <= instr_word[`RSM_U_HI:`RSM_U_LO];
							state     <= ST_RDU;
						end
					end
				end
				ST_RDU: begin
					if (mem_rd_en) begin
						mem_rd_en <= 1'b0;
					end else begin
						opu <= mem_rd_data;
						if (needs_v) begin
							mem_rd_en <= 1'b1;
							mem_addr  <= v;
							state     <= ST_RDV;
						end else begin
							state <= ST_EXEC;
						end
					end
				end
				ST_RDV: begin
					if (mem_rd_en) begin
						mem_rd_en <= 1'b0;
					end else begin
						opv   <= mem_rd_data;
						state <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					state    <= ST_FIN;
					mem_addr <= u;
					case (op)
						`RSM_OP_REPLACE_ADD: begin
							acc         <= sum_uv;
							mem_wr_data <= sum_uv[35:0];
							mem_wr_en   <= 1'b1;
							state       <= ST_WR;
						end
						`RSM_OP_REPLACE_SUB: begin
							acc         <= dif_uv;
							mem_wr_data <= dif_uv[35:0];
							mem_wr_en   <= 1'b1;
							state       <= ST_WR;
						end
						`RSM_OP_CTRL_COMPL: begin
							acc[35:0]   <= opu ^ opv;
							mem_wr_data <= opu ^ opv;
							mem_wr_en   <= 1'b1;
							state       <= ST_WR;
						end
						`RSM_OP_ROT_ACC_STORE: begin
							acc         <= rot_a;
							mem_wr_data <= rot_a[35:0];
							mem_wr_en   <= 1'b1;
							state       <= ST_WR;
						end
						`RSM_OP_ROT_Q_STORE: begin
							q_reg       <= rot_q;
							mem_wr_data <= rot_q;
							mem_wr_en   <= 1'b1;
							state       <= ST_WR;
						end
						`RSM_OP_ZEXT_LOAD, `RSM_OP_ZEXT_ADD,
						`RSM_OP_ZEXT_NEG_LOAD, `RSM_OP_ZEXT_SUB: begin
							acc <= rot_a;
						end
						`RSM_OP_MASK_MOVE: begin
							acc         <= mask_u;
							mem_addr    <= v;
							mem_wr_data <= mask_u[35:0];
							mem_wr_en   <= 1'b1;
							state       <= ST_WR;
						end
						`RSM_OP_MASK_ACC: begin
							acc         <= mask_sum;
							mem_addr    <= v;
							mem_wr_data <= mask_sum[35:0];
							mem_wr_en   <= 1'b1;
							state       <= ST_WR;
						end
						`RSM_OP_MASK_MERGE: begin
							mem_addr    <= v;
							mem_wr_data <= merge_v;
							mem_wr_en   <= 1'b1;
							state       <= ST_WR;
						end
						`RSM_OP_MULTIPLY, `RSM_OP_MUL_ACC: begin
							q_reg <= opu;
							neg_a <= opu[35] ^ opv[35];
							wa    <= 72'h0;
							wb    <= {36'h0, opv[35] ? (36'h0 - opv) : opv};
							rem   <= {1'b0, opu[35] ? (36'h0 - opu) : opu};
							cnt   <= `RSM_MUL_STEPS;
							state <= ST_MUL;
						end
						`RSM_OP_DIVIDE: begin
							neg_a <= acc[71];
							neg_d <= opu[35];
							wa    <= acc[71] ? (72'h0 - acc) : acc;
							wb    <= {36'h0, opu[35] ? (36'h0 - opu) : opu};
							rem   <= 37'h0;
							cnt   <= `RSM_DIV_STEPS;
							state <= ST_DIV;
						end
						`RSM_OP_NORM_COUNT: begin
							acc   <= {pre_norm[35:0], pre_norm[71:36]};
							cnt   <= `RSM_NORM_FIRST;
							state <= ST_NORM;
						end
						`RSM_OP_REPEAT_NEXT: begin
							rep_j     <= u[`RSM_J_HI:`RSM_J_LO];
							rep_n     <= u[`RSM_N_HI:`RSM_N_LO];
							rep_w     <= v;
							rmw_val   <= v;
							mem_addr  <= EXIT_CELL;
							mem_rd_en <= 1'b1;
							state     <= ST_RMW;
						end
						`RSM_OP_IDX_DEC_JUMP: begin
							acc <= idx_dec;
							if (!idx_dec[71]) begin
								jmp         <= 1'b1;
								jmp_addr    <= v;
								mem_wr_data <= idx_dec[35:0];
								mem_wr_en   <= 1'b1;
								state       <= ST_WR;
							end
						end
						`RSM_OP_THRESH_JUMP, `RSM_OP_EQUAL_JUMP: begin
							if (((op == `RSM_OP_THRESH_JUMP) && ($signed(du) > $signed(acc))) ||
								((op == `RSM_OP_EQUAL_JUMP) && (du == acc))) begin
								jmp      <= 1'b1;
								jmp_addr <= v;
								if (rep_run)
									q_reg <= {21'h0, rep_j, rep_n - rep_r - 12'h001};
							end
						end
						default: begin
							state <= ST_FIN;
						end
					endcase
				end
				ST_MUL: begin
					if (cnt == 7'h00) begin
						if (op == `RSM_OP_MUL_ACC) begin
							acc <= prod_sum;
							if (prod_ovf)
								fault <= 1'b1;
						end else begin
							acc <= prod;
						end
						state <= ST_FIN;
					end else begin
						if (rem[0])
							wa <= wa + wb;
						wb  <= {wb[70:0], 1'b0};
						rem <= {1'b0, rem[36:1]};
						cnt <= cnt - 7'h01;
					end
				end
				ST_DIV: begin
					if (cnt == 7'h00) begin
						q_reg       <= q_fin[35:0];
						acc         <= {36'h0, r_fin};
						mem_addr    <= v;
						mem_wr_data <= q_fin[35:0];
						mem_wr_en   <= 1'b1;
						state       <= ST_WR;
					end else begin
						// Quotient bits shift in where dividend bits shift out.
						rem <= rem_ge ? (rem_sh - {1'b0, d_mag}) : rem_sh;
						wa  <= {wa[70:0], rem_ge};
						cnt <= cnt - 7'h01;
					end
				end
				ST_NORM: begin
					// A word of all ones or all zeros never separates, so stop after a full turn.
					if ((acc[34] != acc[35]) || (cnt == `RSM_NORM_LIMIT)) begin
						rmw_val   <= {8'h00, norm_k};
						mem_addr  <= v;
						mem_rd_en <= 1'b1;
						state     <= ST_RMW;
					end else begin
						acc <= {acc[70:0], acc[71]};
						cnt <= cnt + 7'h01;
					end
				end
				ST_RMW: begin
					if (mem_rd_en) begin
						mem_rd_en <= 1'b0;
					end else begin
						mem_wr_data <= {mem_rd_data[35:15], rmw_val};
						mem_wr_en   <= 1'b1;
						state       <= ST_WR;
					end
				end
				ST_WR: begin
					mem_wr_en <= 1'b0;
					state     <= ST_FIN;
				end
				ST_FIN: begin
					if (op == `RSM_OP_REPEAT_NEXT) begin
						rep_armed <= 1'b1;
						rep_run   <= 1'b0;
						busy      <= 1'b0;
						state     <= ST_IDLE;
					end else if (rep_run && !jmp && ((rep_r + 12'h001) != rep_n)) begin
						rep_r <= rep_r + 12'h001;
						if (rep_j[0])
							v <= v + 15'h0001;
						if (rep_j[1])
							u <= u + 15'h0001;
						mem_rd_en <= 1'b1;
						mem_addr  <= rep_j[1] ? (u + 15'h0001) : u;
						state     <= ST_RDU;
					end else begin
						rep_run   <= 1'b0;
						done      <= 1'b1;
						busy      <= 1'b0;
						next_jump <= jmp || rep_run;
						next_addr <= jmp ? jmp_addr : EXIT_CELL;
						state     <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// ==== tb/rsm_monitor.sv ====
`timescale 1ns/10ps
`include "rsm_consts.vh"

module rsm_monitor (
	// Clock and reset
	input wire        sys_clk,
	input wire        rst_n,
	// Instruction port
	input wire        instr_valid,
	input wire [35:0] instr_word,
	input wire        busy,
	input wire        done,
	input wire        next_jump,
	input wire [14:0] next_addr,
	// Storage port
	input wire        mem_rd_en,
	input wire        mem_wr_en,
	input wire [14:0] mem_addr,
	input wire [35:0] mem_wr_data,
	input wire [35:0] mem_rd_data,
	// Registers and fault
	input wire [71:0] acc,
	input wire [35:0] q_reg,
	input wire        fault,
	input wire        fault_clear
);
	reg  [5:0] op_q;
	wire       take;
	wire       acc_op;
	wire       q_op;

	// The word may change after the take edge, so the opcode is held here.
	assign take = instr_valid && !busy;
	assign acc_op = op_q == `RSM_OP_REPLACE_ADD || op_q == `RSM_OP_REPLACE_SUB
		|| op_q == `RSM_OP_CTRL_COMPL || op_q == `RSM_OP_ROT_ACC_STORE
		|| op_q == `RSM_OP_IDX_DEC_JUMP || op_q == `RSM_OP_MASK_MOVE || op_q == `RSM_OP_MASK_ACC;
	assign q_op = op_q == `RSM_OP_ROT_Q_STORE || op_q == `RSM_OP_DIVIDE;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_q <= 6'h00;
		end else if (take) begin
			op_q <= instr_word[35:30];
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	rd_wr_excl_a: assert property (!(mem_rd_en && mem_wr_en))
		else $error("read and write strobes in one cycle");
	take_busy_a: assert property (take |=> busy)
		else $error("taken instruction did not raise busy");
	done_bound_a: assert property (take && instr_word[35:30] != `RSM_OP_REPEAT_NEXT |-> ##[2:400] done)
		else $error("instruction did not complete in time");
	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
	done_idle_a: assert property (done |-> !busy)
		else $error("done while busy");
	rd_strobe_a: assert property (mem_rd_en |=> !mem_rd_en)
		else $error("read strobe longer than one cycle");
	acc_store_a: assert property (mem_wr_en && acc_op |-> mem_wr_data == acc[35:0])
		else $error("stored word differs from accumulator right half");
	q_store_a: assert property (mem_wr_en && q_op |-> mem_wr_data == q_reg)
		else $error("stored word differs from Q");
	store_keeps_a: assert property (mem_wr_en |=> $stable(acc) && $stable(q_reg))
		else $error("store disturbed accumulator or Q");
	jump_hold_a: assert property (!done |-> $stable(next_jump) && $stable(next_addr))
		else $error("next instruction selection changed without done");
	idx_sign_a: assert property (done && op_q == `RSM_OP_IDX_DEC_JUMP |-> next_jump == !acc[71])
		else $error("index jump direction does not follow sign");
	fault_clear_a: assert property (fault_clear && !busy |=> !fault)
		else $error("fault not cleared");
	fault_cause_a: assert property ($rose(fault) |-> op_q == `RSM_OP_MUL_ACC)
		else $error("fault raised outside multiply accumulate");
endmodule

bind rsm_exec rsm_monitor mon_u (.sys_clk, .rst_n, .instr_valid, .instr_word, .busy, .done,
	.next_jump, .next_addr, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wr_data, .mem_rd_data,
	.acc, .q_reg, .fault, .fault_clear);

// ==== tb/rsm_mem_model.sv ====
`timescale 1ns/10ps

module rsm_mem_model (
	// Clock
	input  wire        sys_clk,
	// Storage port
	input  wire        mem_rd_en,
	input  wire        mem_wr_en,
	input  wire [14:0] mem_addr,
	input  wire [35:0] mem_wr_data,
	output wire [35:0] mem_rd_data
);
	logic [35:0] mem [0:32767];
	logic        rd_pend = 1'b0;
	logic [14:0] rd_addr = 15'h0000;
	logic [35:0] last    = 36'h0;

	// Outside the answer cycle the bus shows the inverse of the last word,
	// so a design that samples a cycle late cannot read a lucky match.
	assign mem_rd_data = rd_pend ? mem[rd_addr] : ~last;

	always @(posedge sys_clk) begin
		rd_pend <= mem_rd_en;
		rd_addr <= mem_addr;
		if (rd_pend) begin
			last <= mem[rd_addr];
		end
		if (mem_wr_en) begin
			mem[mem_addr] <= mem_wr_data;
		end
	end
endmodule

// ==== tb/test_replace_split_mask_seq_jump_exec.sv ====
`timescale 1ns/10ps
`include "rsm_consts.vh"

module test_replace_split_mask_seq_jump_exec;
	logic        sys_clk     = 1'b0;
	logic        rst_n       = 1'b0;
	logic        instr_valid = 1'b0;
	logic [35:0] instr_word  = 36'h0;
	logic        fault_clear = 1'b0;
	wire         busy, done, next_jump, mem_rd_en, mem_wr_en, fault;
	wire  [14:0] next_addr, mem_addr;
	wire  [35:0] mem_wr_data, mem_rd_data, q_reg;
	wire  [71:0] acc;
	int          n_fail      = 0;
	int          num_checks  = 0;

	always #10 sys_clk = ~sys_clk;

	rsm_exec dut_u (.sys_clk, .rst_n, .instr_valid, .instr_word, .busy, .done, .next_jump,
		.next_addr, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wr_data, .mem_rd_data, .acc,
		.q_reg, .fault, .fault_clear);
	rsm_mem_model mem_u (.sys_clk, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wr_data, .mem_rd_data);

	function automatic logic [71:0] sx(input logic [35:0] w);
		return {{36{w[35]}}, w};
	endfunction

	function automatic logic [71:0] rl(input logic [71:0] d, input int k);
		return (k == 0) ? d : ((d << k) | (d >> (72 - k)));
	endfunction

	task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic issue(input logic [5:0] op, input logic [14:0] u, input logic [14:0] v);
		@(posedge sys_clk);
		instr_valid <= 1'b1;
		instr_word  <= {op, u, v};
		@(posedge sys_clk);
		instr_valid <= 1'b0;
	endtask

	// Bounded wait: a hung sequence shows up as a failed done check.
	task automatic run(input logic [5:0] op, input logic [14:0] u, input logic [14:0] v);
		issue(op, u, v);
		for (int i = 0; i < 400; i++) begin
			@(negedge sys_clk);
			if (done === 1'b1) break;
		end
		chk("done", 1'b1, done);
	endtask

	task automatic rep(input logic [14:0] u, input logic [14:0] w);
		issue(`RSM_OP_REPEAT_NEXT, u, w);
		for (int i = 0; i < 100; i++) begin
			@(negedge sys_clk);
			if (busy === 1'b0) break;
		end
		chk("rp_free", 1'b0, busy);
	endtask

	task automatic seta(input logic [35:0] w, input logic [6:0] k);
		mem_u.mem[15'h0100] = w;
		run(`RSM_OP_ZEXT_LOAD, 15'h0100, {8'h00, k});
	endtask

	task automatic setq(input logic [35:0] w);
		mem_u.mem[15'h0101] = w;
		run(`RSM_OP_ROT_Q_STORE, 15'h0101, 15'h0000);
	endtask

	task automatic t_replace();
		logic [71:0] e;
		mem_u.mem[15'h0010] = 36'h1_2345;
		mem_u.mem[15'h0011] = 36'h0F0F;
		run(`RSM_OP_REPLACE_ADD, 15'h0010, 15'h0011);
		chk("ra_acc", 72'h1_3254, acc);
		chk("ra_mem", 36'h1_3254, mem_u.mem[15'h0010]);
		run(`RSM_OP_REPLACE_SUB, 15'h0010, 15'h0011);
		chk("rs_acc", 72'h1_2345, acc);
		chk("rs_mem", 36'h1_2345, mem_u.mem[15'h0010]);
		mem_u.mem[15'h0012] = 36'h8_0000_0001;
		run(`RSM_OP_ROT_ACC_STORE, 15'h0012, 15'h0004);
		e = rl(sx(36'h8_0000_0001), 4);
		chk("la_acc", e, acc);
		chk("la_mem", e[35:0], mem_u.mem[15'h0012]);
		run(`RSM_OP_ROT_ACC_STORE, `RSM_ADDR_ACC_DEF, 15'h0003);
		e = rl(e, 3);
		chk("la_self", e, acc);
		mem_u.mem[15'h0013] = 36'hC_3C3C_3C3C;
		mem_u.mem[15'h0014] = 36'hF_0000_FFFF;
		run(`RSM_OP_CTRL_COMPL, 15'h0013, 15'h0014);
		e = {e[71:36], 36'h3_3C3C_C3C3};
		chk("cc_acc", e, acc);
		chk("cc_mem", e[35:0], mem_u.mem[15'h0013]);
		mem_u.mem[15'h0020] = 36'h8_0000_0003;
		run(`RSM_OP_ROT_Q_STORE, 15'h0020, 15'h0003);
		chk("lq_q", 36'h1C, q_reg);
		chk("lq_mem", 36'h1C, mem_u.mem[15'h0020]);
	endtask

	task automatic t_split();
		logic [5:0]  ops [4];
		logic [71:0] e;
		logic [71:0] s;
		ops = '{`RSM_OP_ZEXT_NEG_LOAD, `RSM_OP_ZEXT_LOAD, `RSM_OP_ZEXT_ADD, `RSM_OP_ZEXT_SUB};
		s = {36'h0, 36'h8_0000_00FF};
		mem_u.mem[15'h0030] = s[35:0];
		for (int i = 0; i < 4; i++) begin
			run(ops[i], 15'h0030, 15'h0008);
			case (i)
				0: e = ~s;
				1: e = s;
				2: e = e + s;
				default: e = e - s;
			endcase
			e = rl(e, 8);
			chk("split_acc", e, acc);
		end
	endtask

	task automatic t_mask();
		setq(36'h0_FFFF_0000);
		mem_u.mem[15'h0040] = 36'h1_2345_6789;
		mem_u.mem[15'h0043] = 36'hA_AAAA_AAAA;
		run(`RSM_OP_MASK_MOVE, 15'h0040, 15'h0041);
		chk("qt_acc", 72'h2345_0000, acc);
		chk("qt_mem", 36'h2345_0000, mem_u.mem[15'h0041]);
		run(`RSM_OP_MASK_ACC, 15'h0040, 15'h0042);
		chk("qa_acc", 72'h468A_0000, acc);
		chk("qa_mem", 36'h468A_0000, mem_u.mem[15'h0042]);
		run(`RSM_OP_MASK_MERGE, 15'h0040, 15'h0043);
		chk("qs_mem", 36'hA_2345_AAAA, mem_u.mem[15'h0043]);
		chk("qs_q", 36'hFFFF_0000, q_reg);
	endtask

	task automatic t_seq();
		mem_u.mem[15'h0050] = 36'h3039;
		mem_u.mem[15'h0051] = 36'h2A6;
		run(`RSM_OP_MULTIPLY, 15'h0050, 15'h0051);
		chk("mp_acc", 72'h7F_B6F6, acc);
		chk("mp_q", 36'h3039, q_reg);
		run(`RSM_OP_MUL_ACC, 15'h0050, 15'h0051);
		chk("ma_acc", 72'hFF_6DEC, acc);
		chk("ma_ok", 1'b0, fault);
		seta(36'h7_FFFF_FFFF, 7'h24);
		mem_u.mem[15'h0052] = 36'h7_FFFF_FFFF;
		run(`RSM_OP_MUL_ACC, 15'h0052, 15'h0052);
		chk("ma_fault", 1'b1, fault);
		@(posedge sys_clk);
		fault_clear <= 1'b1;
		@(posedge sys_clk);
		fault_clear <= 1'b0;
		@(negedge sys_clk);
		chk("fault_clr", 1'b0, fault);
		seta(36'h64, 7'h00);
		mem_u.mem[15'h0058] = 36'h7;
		run(`RSM_OP_DIVIDE, 15'h0058, 15'h0059);
		chk("dv_q", 36'hE, q_reg);
		chk("dv_rem", 72'h2, acc);
		chk("dv_mem", 36'hE, mem_u.mem[15'h0059]);
		mem_u.mem[15'h0060] = 36'h100;
		mem_u.mem[15'h0061] = 36'hF_0000_0000;
		run(`RSM_OP_NORM_COUNT, 15'h0060, 15'h0061);
		chk("sf_bits", 1'b1, acc[34] ^ acc[35]);
		chk("sf_count", sx(36'h100), rl(acc, mem_u.mem[15'h0061][14:0] % 72));
		chk("sf_keep", 21'h1E_0000, mem_u.mem[15'h0061][35:15]);
	endtask

	task automatic t_jump();
		logic [35:0] vals [4];
		logic [5:0]  ops [4];
		vals = '{36'h3C, 36'h28, 36'h32, 36'h33};
		ops = '{`RSM_OP_THRESH_JUMP, `RSM_OP_THRESH_JUMP, `RSM_OP_EQUAL_JUMP, `RSM_OP_EQUAL_JUMP};
		mem_u.mem[15'h0070] = 36'h5;
		mem_u.mem[15'h0071] = 36'h0;
		run(`RSM_OP_IDX_DEC_JUMP, 15'h0070, 15'h0123);
		chk("ij_acc", 72'h4, acc);
		chk("ij_mem", 36'h4, mem_u.mem[15'h0070]);
		chk("ij_jump", {1'b1, 15'h0123}, {next_jump, next_addr});
		run(`RSM_OP_IDX_DEC_JUMP, 15'h0071, 15'h0124);
		chk("ij_neg", 2'h1, {next_jump, acc[71]});
		chk("ij_keep", 36'h0, mem_u.mem[15'h0071]);
		seta(36'h32, 7'h00);
		for (int i = 0; i < 4; i++) begin
			mem_u.mem[15'h0072] = vals[i];
			run(ops[i], 15'h0072, 15'h0200);
			chk("cmp_jump", i % 2 == 0, next_jump);
			chk("cmp_acc", 72'h32, acc);
		end
	endtask

	task automatic t_repeat();
		setq(36'hF_FFFF_FFFF);
		mem_u.mem[15'h0000] = 36'h5_5555_5555;
		for (int i = 0; i < 4; i++) begin
			mem_u.mem[15'h0080 + i] = 36'h100 + i;
			mem_u.mem[15'h0090 + i] = 36'h0;
		end
		rep(15'h3003, 15'h0234);
		chk("rp_exit", 36'h5_5555_0234, mem_u.mem[15'h0000]);
		run(`RSM_OP_MASK_MOVE, 15'h0080, 15'h0090);
		for (int i = 0; i < 4; i++) begin
			chk("rp_copy", (i < 3) ? 36'h100 + i : 36'h0, mem_u.mem[15'h0090 + i]);
		end
		chk("rp_next", {1'b1, `RSM_EXIT_CELL_LOW}, {next_jump, next_addr});
		rep(15'h1002, 15'h0235);
		run(`RSM_OP_MASK_MOVE, 15'h0081, 15'h0098);
		chk("rp_j1a", 36'h101, mem_u.mem[15'h0098]);
		chk("rp_j1b", 36'h101, mem_u.mem[15'h0099]);
		seta(36'hA, 7'h00);
		mem_u.mem[15'h00A0] = 36'h14;
		rep(15'h2005, 15'h0300);
		run(`RSM_OP_THRESH_JUMP, 15'h00A0, 15'h0444);
		chk("rp_q", 36'h2004, q_reg);
		chk("rp_jump", {1'b1, 15'h0444}, {next_jump, next_addr});
		chk("rp_acc", 72'hA, acc);
	endtask

	initial begin
		#400000;
		n_fail++;
		$display("BAD watchdog expected finish seen hang");
		complete_run();
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_replace();
		t_split();
		t_mask();
		t_seq();
		t_jump();
		t_repeat();
		complete_run();
	end
endmodule
